// ===== logic/fdnp_port.sv
`timescale 1ns/100ps
// Summary of operation
// - Mode strap high splits port into simultaneous 6-bit transmit and receive buses.
// - Samples move as 6-bit nibbles, two nibbles per internal word.
// - Device drives one port clock at nibble rate for both buses.
// - Clock control bit 2 routes buffered oscillator input to port clock.
// - Two transmit nibbles join into one 10-bit twos complement word.
// - Transmit nibbles sampled on port clock rising edge by default.
// - Sync-low nibble is most significant, next sync-high nibble least significant.
// - Sync held low re-reads latest transmit data until a new second nibble.
// - Receive 12-bit twos complement word sent as two nibbles, rising-edge valid.
// - Receive MS nibble sent with sync low, LS nibble with sync high.
// - Option bit 0 switches each path to straight binary.
// - Option bit 4 inverts sync polarity; bit 2 sends LS nibble first.
// - Option bit 1 moves each port's edge to falling clock edge.
// - Clock control bit 1 inverts port clock, bit 0 disables it.
// - Receive gain 6-bit code, reset to minimum -12 dB.
// - Serial gain access acts only when its bit 6 is set.
// - Gain load over transmit bus only in full-duplex, enabled by default.
// - Strobe high with sync low loads gain code on selected edge.
// - Strobe low routes transmit nibbles to the interpolator path.
// - Gain port passes directly to register chosen by select bits 5, 6.
// - 3-bit mapping takes code from upper gain port bits, 8 dB steps.
// - Codes 000 and 001 give minimum; each higher code adds 8 dB.
// - Select bit 3 asserts the gain strobe internally for continuous updates.
module fdnp_port (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Straps and clock sources
    input wire logic mode_full_duplex,
    input wire logic synth_clock,
    input wire logic oscillator_input,
    // Port clock
    output logic port_clock_out,
    output logic port_clock_out_oe,
    // Transmit nibble bus
    input wire logic [5:0] tx_nibble,
    input wire logic tx_word_sync,
    input wire logic gain_strobe,
    input wire logic tx_quiet_input,
    // Receive nibble bus
    output logic [5:0] rx_nibble,
    output logic rx_word_sync,
    output logic rx_nibble_oe,
    // Gain word port
    input wire logic [5:0] gain_word_port,
    // Register port
    input wire logic reg_wr,
    input wire fdnp_pkg::fdnp_reg_wr_t reg_wr_req,
    input wire logic [3:0] reg_rd_addr,
    output logic [7:0] reg_rd_data,
    // Sample paths
    output logic [9:0] tx_word,
    output logic tx_word_valid,
    output logic tx_output_enable,
    input wire logic rx_in_valid,
    output logic rx_in_ready,
    input wire fdnp_pkg::fdnp_rx_word_t rx_in,
    output logic [5:0] rx_gain_amp,
    output logic [5:0] tx_gain_amp
);
    import fdnp_pkg::*;

    logic [7:0] clkc_q, rxg_q, gsrc_q, txo_q, rxo_q, drv_q;
    logic [1:0] mode_s_q, syn_s_q, osc_s_q;
    logic [5:0] txn_s0_q, txn_s1_q, gwp_s0_q, gwp_s1_q;
    logic [2:0] txc_s0_q, txc_s1_q;
    logic pclk_q;
    logic [5:0] tx_ms_q;
    logic [9:0] tx_word_q;
    logic tx_valid_q;
    logic [5:0] rx_nib_q;
    logic rx_sync_q;
    logic [5:0] rx_lo_q;
    logic rx_half_q;
    logic [5:0] txg_q;
    logic rx_gain_wr;
    logic src_clk_d, pclk_d, rise_i, fall_i, tx_edge, rx_edge, full_dup;
    logic tx_first, strobe, rx_pop, rx_avail;
    logic [11:0] rx_fmt;
    fdnp_rx_word_t rx_head;

    // Converts the 3-bit mapped code to a 6-bit step code (one step per dB)
    function automatic logic [5:0] fdnp_map3(input logic [2:0] c);
        fdnp_map3 = (c < 3'h2) ? FDNP_GAIN_MIN : 6'((c - 3'h1) * FDNP_MAP3_STEP);
    endfunction : fdnp_map3

    // Picks the active edge for a port from its option byte
    function automatic logic fdnp_edge(input logic [7:0] o, input logic r, input logic f);
        fdnp_edge = o[FDNP_OPT_NEG] ? f : r;
    endfunction : fdnp_edge

    // Two-flop synchronisers for every pin input
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mode_s_q <= 2'h0;
            syn_s_q <= 2'h0;
            osc_s_q <= 2'h0;
            txn_s0_q <= 6'h00;
            txn_s1_q <= 6'h00;
            txc_s0_q <= 3'h0;
            txc_s1_q <= 3'h0;
            gwp_s0_q <= 6'h00;
            gwp_s1_q <= 6'h00;
        end
        else
        begin
            mode_s_q <= {mode_s_q[0], mode_full_duplex};
            syn_s_q <= {syn_s_q[0], synth_clock};
            osc_s_q <= {osc_s_q[0], oscillator_input};
            txn_s0_q <= tx_nibble;
            txn_s1_q <= txn_s0_q;
            txc_s0_q <= {tx_word_sync, gain_strobe, tx_quiet_input};
            txc_s1_q <= txc_s0_q;
            gwp_s0_q <= gain_word_port;
            gwp_s1_q <= gwp_s0_q;
        end
    end

    assign full_dup = mode_s_q[1];
    // Source select: oscillator copy lets the synthesizer power down
    assign src_clk_d = clkc_q[FDNP_CLK_OSC] ? osc_s_q[1] : syn_s_q[1];
    assign pclk_d = src_clk_d ^ clkc_q[FDNP_CLK_INV];
    assign rise_i = pclk_d && !pclk_q;
    assign fall_i = !pclk_d && pclk_q;
    assign tx_edge = fdnp_edge(txo_q, rise_i, fall_i);
    assign rx_edge = fdnp_edge(rxo_q, rise_i, fall_i);

    // Port clock follows the selected source at nibble rate
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pclk_q <= 1'b0;
        end
        else
        begin
            pclk_q <= pclk_d;
        end
    end
    assign port_clock_out = pclk_q;
    assign port_clock_out_oe = full_dup && !clkc_q[FDNP_CLK_DIS];

    // Register writes; serial gain access needs its enable bit
    assign rx_gain_wr = reg_wr && reg_wr_req.addr == FDNP_REG_RXGAIN
        && reg_wr_req.data[FDNP_RXG_EN];
    assign strobe = txc_s1_q[1] || gsrc_q[FDNP_GS_SWSTB];
    assign tx_first = txc_s1_q[2] == txo_q[FDNP_OPT_INVS];

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            clkc_q <= FDNP_ZERO8;
            gsrc_q <= FDNP_GSRC_RST;
            txo_q <= FDNP_ZERO8;
            rxo_q <= FDNP_ZERO8;
            drv_q <= FDNP_ZERO8;
        end
        else if (reg_wr)
        begin
            case (reg_wr_req.addr)
                FDNP_REG_CLK: clkc_q <= reg_wr_req.data;
                FDNP_REG_GSRC: gsrc_q <= reg_wr_req.data;
                FDNP_REG_TXOPT: txo_q <= reg_wr_req.data;
                FDNP_REG_RXOPT: rxo_q <= reg_wr_req.data;
                FDNP_REG_DRIVE: drv_q <= reg_wr_req.data;
                default: ;
            endcase
        end
    end

    // Receive gain register: serial, transmit bus and gain port sources
    always_ff @(posedge clk)
    begin
        if (reset)
            rxg_q <= {2'h0, FDNP_GAIN_MIN};
        else if (rx_gain_wr)
            rxg_q <= {2'h0, reg_wr_req.data[5:0]};
        else if (full_dup && gsrc_q[FDNP_GS_TXBUS] && strobe && tx_edge
            && txc_s1_q[2] == txo_q[FDNP_OPT_INVS])
            rxg_q <= {2'h0, txn_s1_q};
        else if (gsrc_q[FDNP_GS_RXPORT])
            rxg_q <= {2'h0, gsrc_q[FDNP_GS_MAP3] ? fdnp_map3(gwp_s1_q[5:3])
                : gwp_s1_q};
    end

    // Transmit gain via gain port only
    always_ff @(posedge clk)
    begin
        if (reset)
            txg_q <= FDNP_GAIN_MIN;
        else if (gsrc_q[FDNP_GS_TXPORT])
            txg_q <= gwp_s1_q;
    end
    assign rx_gain_amp = rxg_q[5:0];
    assign tx_gain_amp = txg_q;

    // Transmit assembly: first-nibble phase keeps re-reading latest data
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            tx_ms_q <= 6'h00;
            tx_word_q <= 10'h000;
            tx_valid_q <= 1'b0;
        end
        else
        begin
            tx_valid_q <= 1'b0;
            if (full_dup && tx_edge && !strobe)
            begin
                if (tx_first)
                    tx_ms_q <= txn_s1_q;
                else
                begin
                    tx_word_q <= txo_q[FDNP_OPT_LSF]
                        ? {txn_s1_q[4:0], tx_ms_q[4:0]} ^ {txo_q[FDNP_OPT_BIN], 9'h000}
                        : {tx_ms_q[4:0], txn_s1_q[4:0]} ^ {txo_q[FDNP_OPT_BIN], 9'h000};
                    tx_valid_q <= 1'b1;
                end
            end
        end
    end
    assign tx_word = tx_word_q;
    assign tx_word_valid = tx_valid_q;
    assign tx_output_enable = txc_s1_q[0];

    // Receive words buffered, then sent high nibble first by default
    fdnp_fifo #(.WIDTH(12), .DEPTH(FDNP_FIFO_DEPTH)) u_rx_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(rx_in_valid),
        .in_ready(rx_in_ready),
        .in_data(rx_in.data),
        .out_valid(rx_avail),
        .out_ready(rx_pop),
        .out_data(rx_head.data)
    );
    assign rx_pop = full_dup && rx_edge && !rx_half_q && rx_avail;
    assign rx_fmt = rx_head.data ^ {rxo_q[FDNP_OPT_BIN], 11'h000};

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rx_nib_q <= 6'h00;
            rx_sync_q <= 1'b0;
            rx_lo_q <= 6'h00;
            rx_half_q <= 1'b0;
        end
        else if (full_dup && rx_edge)
        begin
            if (!rx_half_q)
            begin
                if (rx_avail)
                begin
                    rx_nib_q <= rxo_q[FDNP_OPT_LSF] ? rx_fmt[5:0] : rx_fmt[11:6];
                    rx_lo_q <= rxo_q[FDNP_OPT_LSF] ? rx_fmt[11:6] : rx_fmt[5:0];
                    rx_sync_q <= rxo_q[FDNP_OPT_INVS];
                    rx_half_q <= 1'b1;
                end
            end
            else
            begin
                rx_nib_q <= rx_lo_q;
                rx_sync_q <= !rxo_q[FDNP_OPT_INVS];
                rx_half_q <= 1'b0;
            end
        end
    end
    assign rx_nibble = rx_nib_q;
    assign rx_word_sync = rx_sync_q;
    assign rx_nibble_oe = full_dup;

    // Register readback; gain reads always return the enable bit set
    always_comb
    begin
        case (reg_rd_addr)
            FDNP_REG_CLK: reg_rd_data = clkc_q;
            FDNP_REG_RXGAIN: reg_rd_data = {2'h1, rxg_q[5:0]};
            FDNP_REG_GSRC: reg_rd_data = gsrc_q;
            FDNP_REG_TXOPT: reg_rd_data = txo_q;
            FDNP_REG_RXOPT: reg_rd_data = rxo_q;
            FDNP_REG_DRIVE: reg_rd_data = drv_q;
            default: reg_rd_data = FDNP_ZERO8;
        endcase
    end

    // Checks
    chk_gain_reset: assert property (@(posedge clk) $fell(reset) |-> rx_gain_amp == 6'h00)
        else $error("gain not minimum after reset");
    chk_tx_valid_one: assert property (@(posedge clk) disable iff (reset)
        tx_word_valid |=> !tx_word_valid)
        else $error("tx word valid longer than one cycle");
    chk_no_tx_half: assert property (@(posedge clk) disable iff (reset)
        !full_dup |=> !tx_word_valid)
        else $error("tx word in half duplex");
    chk_rx_sync_pair: assert property (@(posedge clk) disable iff (reset)
        (rx_edge && full_dup && rx_half_q) |=> rx_word_sync == !rxo_q[FDNP_OPT_INVS])
        else $error("second rx nibble sync wrong");
    chk_rx_first_sync: assert property (@(posedge clk) disable iff (reset)
        rx_pop |=> rx_word_sync == rxo_q[FDNP_OPT_INVS])
        else $error("first rx nibble sync wrong");
    chk_clk_dis: assert property (@(posedge clk) disable iff (reset)
        clkc_q[FDNP_CLK_DIS] |-> !port_clock_out_oe)
        else $error("port clock driven while disabled");
    // Pin to output is three flops; checked only while the control byte rests at default
    chk_clk_follow: assert property (@(posedge clk) disable iff (reset)
        (clkc_q == FDNP_ZERO8 && $past(clkc_q, 3) == FDNP_ZERO8 && !$past(reset, 3))
        |-> port_clock_out == $past(synth_clock, 3))
        else $error("port clock not tracking source");
    chk_strobe_block: assert property (@(posedge clk) disable iff (reset)
        strobe |=> !tx_word_valid)
        else $error("tx word while gain strobe high");
    chk_ser_gain: assert property (@(posedge clk) disable iff (reset)
        rx_gain_wr |=> rx_gain_amp == $past(reg_wr_req.data[5:0]))
        else $error("serial gain write lost");
    chk_gain_bus_load: assert property (@(posedge clk) disable iff (reset)
        (full_dup && gsrc_q[FDNP_GS_TXBUS] && strobe && tx_edge && tx_first && !rx_gain_wr)
        |=> rx_gain_amp == $past(txn_s1_q))
        else $error("gain code from transmit bus lost");
    chk_tx_gain_port: assert property (@(posedge clk) disable iff (reset)
        gsrc_q[FDNP_GS_TXPORT] |=> tx_gain_amp == $past(gwp_s1_q))
        else $error("transmit gain not following gain port");
    chk_half_rx: assert property (@(posedge clk) disable iff (reset)
        !full_dup |=> $stable(rx_nibble))
        else $error("rx nibble moved in half duplex");
    // Main scenarios
    cov_tx_word: cover property (@(posedge clk) tx_word_valid);
    cov_rx_word: cover property (@(posedge clk) rx_pop);
    cov_gain_tx: cover property (@(posedge clk) strobe && tx_edge && full_dup);
    cov_lsf_word: cover property (@(posedge clk) tx_word_valid && txo_q[FDNP_OPT_LSF]);
    cov_map3_gain: cover property (@(posedge clk) gsrc_q[FDNP_GS_RXPORT] && gsrc_q[FDNP_GS_MAP3]);
endmodule : fdnp_port

// ===== logic/fdnp_pkg.sv
package fdnp_pkg;
    // Register indices
    localparam logic [3:0] FDNP_REG_CLK = 4'h5;
    localparam logic [3:0] FDNP_REG_RXGAIN = 4'h9;
    localparam logic [3:0] FDNP_REG_GSRC = 4'hb;
    localparam logic [3:0] FDNP_REG_TXOPT = 4'hc;
    localparam logic [3:0] FDNP_REG_RXOPT = 4'hd;
    localparam logic [3:0] FDNP_REG_DRIVE = 4'he;
    // Port clock control bits
    localparam int FDNP_CLK_DIS = 0;
    localparam int FDNP_CLK_INV = 1;
    localparam int FDNP_CLK_OSC = 2;
    // Gain source select bits
    localparam int FDNP_GS_MAP3 = 1;
    localparam int FDNP_GS_TXBUS = 2;
    localparam int FDNP_GS_SWSTB = 3;
    localparam int FDNP_GS_RXPORT = 5;
    localparam int FDNP_GS_TXPORT = 6;
    // Port option bits
    localparam int FDNP_OPT_BIN = 0;
    localparam int FDNP_OPT_NEG = 1;
    localparam int FDNP_OPT_LSF = 2;
    localparam int FDNP_OPT_INVS = 4;
    localparam int FDNP_RXG_EN = 6;
    // Reset values
    localparam logic [7:0] FDNP_GSRC_RST = 8'h04;
    localparam logic [7:0] FDNP_ZERO8 = 8'h00;
    localparam logic [5:0] FDNP_GAIN_MIN = 6'h00;
    localparam logic [5:0] FDNP_MAP3_STEP = 6'h08;
    localparam int FDNP_FIFO_DEPTH = 4;
    // Receive word carrier
    typedef struct packed {
        logic [11:0] data;
    } fdnp_rx_word_t;
    // Register write request carrier
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
    } fdnp_reg_wr_t;
endpackage : fdnp_pkg

// ===== logic/fdnp_fifo.sv
`timescale 1ns/100ps
module fdnp_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];
    // Storage
    always_ff @(posedge clk)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end
    // Pointers and fill count
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : fdnp_fifo

// ===== verif/fdnp_ctrl_model.sv
`timescale 1ns/100ps
module fdnp_ctrl_model (
    // System clock for input alignment
    input wire logic clk,
    // From the device
    input wire logic port_clock_out,
    input wire logic [5:0] rx_nibble,
    input wire logic rx_word_sync,
    // To the device
    output logic [5:0] tx_nibble,
    output logic tx_word_sync
);
    logic inv = 1'b0; // Tx sync level of the first nibble
    logic act = 1'b1; // Port clock level after the sampling edge
    logic rinv = 1'b0; // Rx sync level of the first nibble
    logic have = 1'b0;
    logic [5:0] first = 6'h00;
    logic [11:0] rq[$];
    // Idle levels at time zero
    initial
    begin
        tx_nibble = 6'h00;
        tx_word_sync = 1'b0;
    end
    // Change on the inactive edge, so data is stable around the sampling one
    task automatic drive(input logic [5:0] n, input logic s);
        @(port_clock_out iff port_clock_out != act);
        @(negedge clk);
        tx_nibble = n;
        tx_word_sync = s;
    endtask : drive
    // Extra first-phase nibbles, then the word's first and second nibbles
    task automatic send(input logic [5:0] f0, input int n, input logic [5:0] f,
        input logic [5:0] s);
        repeat (n) drive(f0, inv);
        drive(f, inv);
        drive(s, !inv);
    endtask : send
    // Gain code held with sync in its first phase
    task automatic hold(input logic [5:0] g, input int n);
        repeat (n) drive(g, inv);
    endtask : hold
    // Pair received nibbles, sampled mid-period
    always @(negedge port_clock_out)
    begin
        if (rx_word_sync == rinv)
        begin
            first <= rx_nibble;
            have <= 1'b1;
        end
        else if (have)
        begin
            rq.push_back({first, rx_nibble});
            have <= 1'b0;
        end
    end
endmodule : fdnp_ctrl_model

// ===== verif/test_fdnp_port.sv
`timescale 1ns/100ps
module test_fdnp_port;
    import fdnp_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic mode_full_duplex = 1'b1;
    logic synth_clock = 1'b0;
    logic oscillator_input = 1'b0;
    logic gain_strobe = 1'b0;
    logic tx_quiet_input = 1'b1;
    logic [5:0] gain_word_port = 6'h00;
    logic reg_wr = 1'b0;
    fdnp_reg_wr_t reg_wr_req = 12'h000;
    logic [3:0] reg_rd_addr = 4'h0;
    logic rx_in_valid = 1'b0;
    fdnp_rx_word_t rx_in = 12'h000;
    logic [5:0] tx_nibble, rx_nibble, rx_gain_amp, tx_gain_amp;
    logic tx_word_sync, rx_word_sync, port_clock_out, port_clock_out_oe, rx_nibble_oe;
    logic tx_word_valid, tx_output_enable, rx_in_ready;
    logic [7:0] reg_rd_data;
    logic [9:0] tx_word;
    logic [9:0] txq[$];
    logic refused = 1'b0;
    int mismatches = 0;
    int checks = 0;
    int v;
    // Clocks: system, link (free running, odd phase), alternate source
    initial
    begin
        forever #5 clk = ~clk;
    end
    initial
    begin
        #3.3;
        forever #62.5 synth_clock = ~synth_clock;
    end
    initial
    begin
        forever #125 oscillator_input = ~oscillator_input;
    end
    fdnp_port i_fdnp_port (.clk(clk), .reset(reset), .mode_full_duplex(mode_full_duplex),
        .synth_clock(synth_clock), .oscillator_input(oscillator_input),
        .port_clock_out(port_clock_out), .port_clock_out_oe(port_clock_out_oe),
        .tx_nibble(tx_nibble), .tx_word_sync(tx_word_sync), .gain_strobe(gain_strobe),
        .tx_quiet_input(tx_quiet_input), .rx_nibble(rx_nibble),
        .rx_word_sync(rx_word_sync), .rx_nibble_oe(rx_nibble_oe),
        .gain_word_port(gain_word_port), .reg_wr(reg_wr), .reg_wr_req(reg_wr_req),
        .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .tx_word(tx_word),
        .tx_word_valid(tx_word_valid), .tx_output_enable(tx_output_enable),
        .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready), .rx_in(rx_in),
        .rx_gain_amp(rx_gain_amp), .tx_gain_amp(tx_gain_amp));
    fdnp_ctrl_model i_fdnp_ctrl_model (.clk(clk), .port_clock_out(port_clock_out),
        .rx_nibble(rx_nibble), .rx_word_sync(rx_word_sync), .tx_nibble(tx_nibble),
        .tx_word_sync(tx_word_sync));
    // Collect transmit words
    always @(posedge clk)
    begin
        if (tx_word_valid === 1'b1)
            txq.push_back(tx_word);
    end
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_wr_req = {a, d};
        @(negedge clk);
        reg_wr = 1'b0;
        repeat (2) @(negedge clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_rd_addr = a;
        #1;
        check("reg_rd_data", {4'h0, reg_rd_data}, {4'h0, exp});
    endtask : rd
    // One word through the model, then the first word seen
    task automatic txw(input logic [9:0] exp, input logic [5:0] f0, input int n,
        input logic [5:0] f, input logic [5:0] s);
        int i;
        txq.delete();
        i_fdnp_ctrl_model.send(f0, n, f, s);
        for (i = 0; i < 60 && txq.size() == 0; i++)
            @(posedge clk);
        check("tx_word", (txq.size() > 0) ? {2'b00, txq[0]} : 12'hfff, {2'b00, exp});
    endtask : txw
    // Gain over the transmit bus; pin strobe level given
    task automatic gload(input logic pin, input logic [5:0] g, input logic [5:0] exp);
        @(negedge clk);
        gain_strobe = pin;
        // Let the strobe clear the pin synchroniser before counting words
        repeat (4) @(negedge clk);
        txq.delete();
        i_fdnp_ctrl_model.hold(g, 3);
        @(negedge clk);
        gain_strobe = 1'b0;
        repeat (10) @(negedge clk);
        check("rx_gain_amp", {6'h00, rx_gain_amp}, {6'h00, exp});
        check("tx_word_count", 12'(txq.size()), 12'h000);
    endtask : gload
    // Push with valid held until ready is sampled high
    task automatic rxpush(input logic [11:0] w);
        int i;
        @(negedge clk);
        rx_in_valid = 1'b1;
        rx_in = w;
        // Ready only moves on a rising edge, so a mid-cycle look is settled
        for (i = 0; i < 400 && rx_in_ready !== 1'b1; i++)
        begin
            refused = 1'b1;
            @(negedge clk);
        end
        check("rx_in_ready", {11'h000, rx_in_ready}, 12'h001);
        @(posedge clk);
    endtask : rxpush
    function automatic logic has(input logic [11:0] raw);
        int i;
        has = 1'b0;
        for (i = 0; i < i_fdnp_ctrl_model.rq.size(); i++)
            if (i_fdnp_ctrl_model.rq[i] === raw)
                has = 1'b1;
    endfunction : has
    // Seven words back to back overrun the four-word buffer
    task automatic rxrun(input logic [7:0] opt, input logic inv);
        int i;
        logic [11:0] w;
        wr(FDNP_REG_RXOPT, opt);
        i_fdnp_ctrl_model.rinv = inv;
        i_fdnp_ctrl_model.rq.delete();
        refused = 1'b0;
        for (i = 0; i < 7; i++)
            rxpush(12'h9c3 + 12'h111 * 12'(i));
        @(negedge clk);
        rx_in_valid = 1'b0;
        repeat (300) @(negedge clk);
        check("rx_in_refused", {11'h000, refused}, 12'h001);
        check("rx_in_ready", {11'h000, rx_in_ready}, 12'h001);
        for (i = 0; i < 7; i++)
        begin
            w = (12'h9c3 + 12'h111 * 12'(i)) ^ (opt[0] ? 12'h800 : 12'h000);
            check("rx_word", {11'h000, has(opt[2] ? {w[5:0], w[11:6]} : w)}, 12'h001);
        end
    endtask : rxrun
    // Port clock level just after a link clock rise
    task automatic pphase(input logic exp);
        @(posedge synth_clock);
        #50;
        check("port_clock_out", {11'h000, port_clock_out}, {11'h000, exp});
    endtask : pphase
    // Rising port clock edges over 2500 ns, one either way allowed
    task automatic pcount(input int exp);
        int i;
        int n;
        logic p;
        n = 0;
        p = port_clock_out;
        for (i = 0; i < 250; i++)
        begin
            @(posedge clk);
            if (port_clock_out === 1'b1 && p === 1'b0)
                n++;
            p = port_clock_out;
        end
        check("port_clock_rate", {11'h000, n >= exp - 1 && n <= exp + 1}, 12'h001);
    endtask : pcount
    // Hang guard, well past the expected run
    initial
    begin
        #400000;
        mismatches++;
        $display("watchdog expired");
        end_of_test();
    end
    // Test sequence
    initial
    begin
        repeat (10) @(negedge clk);
        reset = 1'b0;
        rd(FDNP_REG_CLK, FDNP_ZERO8);
        rd(FDNP_REG_GSRC, FDNP_GSRC_RST);
        rd(FDNP_REG_TXOPT, FDNP_ZERO8);
        rd(FDNP_REG_RXOPT, FDNP_ZERO8);
        rd(FDNP_REG_DRIVE, FDNP_ZERO8);
        check("rx_gain_amp", {6'h00, rx_gain_amp}, {6'h00, FDNP_GAIN_MIN});
        wr(FDNP_REG_DRIVE, 8'h80);
        rd(FDNP_REG_DRIVE, 8'h80);
        repeat (20) @(negedge clk);
        check("rx_nibble_oe", {11'h000, rx_nibble_oe}, 12'h001);
        check("tx_output_enable", {11'h000, tx_output_enable}, 12'h001);
        $display("test defaults done");
        txw(10'h2a5, 6'h00, 0, 6'h15, 6'h05);
        txw(10'h15a, 6'h00, 0, 6'h2a, 6'h1a);
        txw(10'h0e3, 6'h1f, 3, 6'h07, 6'h03);
        // Bits 7:6 stay 00, keeping 4x interpolation
        wr(FDNP_REG_TXOPT, 8'h15);
        i_fdnp_ctrl_model.inv = 1'b1;
        txw(10'h0a5, 6'h00, 0, 6'h05, 6'h15);
        wr(FDNP_REG_TXOPT, 8'h02);
        i_fdnp_ctrl_model.inv = 1'b0;
        i_fdnp_ctrl_model.act = 1'b0;
        txw(10'h15a, 6'h00, 0, 6'h2a, 6'h1a);
        wr(FDNP_REG_TXOPT, 8'h00);
        i_fdnp_ctrl_model.act = 1'b1;
        $display("test transmit done");
        wr(FDNP_REG_RXGAIN, 8'h3c);
        check("rx_gain_amp", {6'h00, rx_gain_amp}, 12'h000);
        wr(FDNP_REG_RXGAIN, 8'h7c);
        check("rx_gain_amp", {6'h00, rx_gain_amp}, 12'h03c);
        rd(FDNP_REG_RXGAIN, 8'h7c);
        gload(1'b1, 6'h11, 6'h11);
        wr(FDNP_REG_GSRC, 8'h00);
        gload(1'b1, 6'h22, 6'h11);
        wr(FDNP_REG_GSRC, 8'h0c);
        gload(1'b0, 6'h23, 6'h23);
        gain_word_port = 6'h15;
        wr(FDNP_REG_GSRC, 8'h20);
        repeat (8) @(negedge clk);
        check("rx_gain_amp", {6'h00, rx_gain_amp}, 12'h015);
        // Deselect, present, then select the transmit register
        wr(FDNP_REG_GSRC, 8'h00);
        gain_word_port = 6'h2a;
        wr(FDNP_REG_GSRC, 8'h40);
        repeat (8) @(negedge clk);
        check("tx_gain_amp", {6'h00, tx_gain_amp}, 12'h02a);
        check("rx_gain_amp", {6'h00, rx_gain_amp}, 12'h015);
        wr(FDNP_REG_GSRC, 8'h22);
        for (v = 0; v < 8; v++)
        begin
            gain_word_port = {3'(v), 3'h5};
            repeat (8) @(negedge clk);
            check("map3_gain", {6'h00, rx_gain_amp},
                {6'h00, (v < 2) ? 6'h00 : FDNP_MAP3_STEP * 6'(v - 1)});
        end
        $display("test gain done");
        rxrun(8'h00, 1'b0);
        rxrun(8'h15, 1'b1);
        $display("test receive done");
        pphase(1'b1);
        pcount(20);
        wr(FDNP_REG_CLK, 8'h02);
        pphase(1'b0);
        wr(FDNP_REG_CLK, 8'h04);
        pcount(10);
        wr(FDNP_REG_CLK, 8'h01);
        check("port_clock_out_oe", {11'h000, port_clock_out_oe}, 12'h000);
        wr(FDNP_REG_CLK, 8'h00);
        check("port_clock_out_oe", {11'h000, port_clock_out_oe}, 12'h001);
        $display("test clock done");
        mode_full_duplex = 1'b0;
        repeat (10) @(negedge clk);
        check("rx_nibble_oe", {11'h000, rx_nibble_oe}, 12'h000);
        check("port_clock_out_oe", {11'h000, port_clock_out_oe}, 12'h000);
        txq.delete();
        i_fdnp_ctrl_model.send(6'h00, 0, 6'h15, 6'h05);
        repeat (60) @(negedge clk);
        check("tx_word_count", 12'(txq.size()), 12'h000);
        $display("test half duplex done");
        end_of_test();
    end
endmodule : test_fdnp_port
